// *** rtl/ompld_core.sv ***
`default_nettype none
module ompld_core (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Instruction words
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_in,
	// AXI4-Lite slave
	input wire logic [ompld_pkg::AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ompld_pkg::AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Core state
	output logic [7:0] accum_out,
	output logic neg_flag_out,
	output logic zero_flag_out,
	output logic ptr_pending_out
);
	import ompld_pkg::*;
	typedef struct packed {
		ompld_phase_t phase;
		logic [1:0] psel;
		logic [7:0] w;
		logic [ST_W-1:0] st;
		logic [3:0] bank_select_reg;
		logic [PTR_NUM-1:0][11:0] ptr;
		logic ext;
		logic [11:0] maddr;
	} ompld_core_t;
	ompld_core_t s_q, s_d;

	logic sw_we;
	logic [AW-1:0] sw_addr;
	logic [31:0] sw_data;
	logic sw_err;
	logic [AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic go;
	logic is_orlit;
	logic is_orreg;
	logic is_move;
	logic is_p1;
	logic p1_legal;
	logic byte_op;
	logic dest_f;
	logic bank_a;
	logic [7:0] fld;
	logic [7:0] opnd;
	logic [7:0] res;
	logic [11:0] faddr;
	logic [7:0] frd;
	logic [7:0] mrd;
	logic mem_we;
	logic [11:0] mem_wa;
	logic [7:0] mem_wd;

	ompld_axil u_bus (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.core_idle_in(!instr_valid_in),
		.wr_en_out(sw_we),
		.wr_addr_out(sw_addr),
		.wr_data_out(sw_data),
		.wr_err_in(sw_err),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_err_in(rd_err)
	);

	ompld_dmem u_mem (
		.clk_in(clk_in),
		.we_in(mem_we),
		.waddr_in(mem_wa),
		.wdata_in(mem_wd),
		.raddr_a_in(faddr),
		.rdata_a_out(frd),
		.raddr_b_in(s_q.maddr),
		.rdata_b_out(mrd)
	);

	// Decode, operand read and processing all settle inside one cycle
	always_comb
	begin
		fld = instr_in[7:0];
		dest_f = instr_in[9];
		bank_a = instr_in[8];
		go = instr_valid_in && (s_q.phase == PH_FETCH);
		is_orlit = go && (instr_in[15:8] == OP_ORLIT);
		is_orreg = go && (instr_in[15:10] == OP_ORREG);
		is_move = go && (instr_in[15:10] == OP_MOVE);
		is_p1 = go && (instr_in[15:6] == OP_PLOAD1);
		p1_legal = instr_in[5:4] <= PTR_SEL_MAX;
		byte_op = is_orlit || is_orreg || is_move;
		if (bank_a)
			faddr = {s_q.bank_select_reg, fld};
		else if (s_q.ext && (fld <= ILO_MAX))
			faddr = s_q.ptr[PTR_IDX_ILO] + {4'h0, fld};
		else if (fld < ACC_SPLIT)
			faddr = {4'h0, fld};
		else
			faddr = {ACC_HI_BANK, fld};
		opnd = is_orlit ? fld : frd;
		res = is_move ? frd : (s_q.w | opnd);
	end

	always_comb
	begin
		s_d = s_q;
		mem_we = 1'b0;
		mem_wa = faddr;
		mem_wd = res;
		sw_err = 1'b0;
		case (s_q.phase)
			PH_FETCH:
			begin
				if (byte_op)
				begin
					if (is_orlit || !dest_f)
						s_d.w = res;
					else
						mem_we = 1'b1;
					// Carry, digit carry and overflow are left alone
					s_d.st[ST_N] = res[7];
					s_d.st[ST_Z] = (res == 8'h00);
				end
				else if (is_p1 && p1_legal)
				begin
					s_d.ptr[instr_in[5:4]][11:8] = instr_in[3:0];
					s_d.psel = instr_in[5:4];
					s_d.phase = PH_PTRLO;
				end
			end
			PH_PTRLO:
			begin
				// A second word of the wrong form abandons the load, high nibble stays written
				if (instr_valid_in)
				begin
					if (instr_in[15:8] == OP_PLOAD2)
						s_d.ptr[s_q.psel][7:0] = fld;
					s_d.phase = PH_FETCH;
				end
			end
			default:
				s_d.phase = PH_FETCH;
		endcase
		case (sw_addr)
			REG_CTRL:
				if (sw_we) s_d.ext = sw_data[CTRL_EXT];
			REG_ACCUM:
				if (sw_we) s_d.w = sw_data[7:0];
			REG_STATUS:
				if (sw_we) s_d.st = sw_data[ST_W-1:0];
			REG_BANK:
				if (sw_we) s_d.bank_select_reg = sw_data[3:0];
			REG_PTR0:
				if (sw_we) s_d.ptr[0] = sw_data[11:0];
			REG_PTR1:
				if (sw_we) s_d.ptr[1] = sw_data[11:0];
			REG_PTR2:
				if (sw_we) s_d.ptr[2] = sw_data[11:0];
			REG_MADDR:
				if (sw_we) s_d.maddr = sw_data[11:0];
			REG_MDATA:
			begin
				// Only a live write takes the port; a stale bus address must not block core write-back
				if (sw_we)
				begin
					mem_we = 1'b1;
					mem_wa = s_q.maddr;
					mem_wd = sw_data[7:0];
				end
			end
			default:
				sw_err = 1'b1;
		endcase
	end

	always_comb
	begin
		rd_data = '0;
		rd_err = 1'b0;
		case (rd_addr)
			REG_CTRL:
				rd_data[CTRL_EXT] = s_q.ext;
			REG_ACCUM:
				rd_data[7:0] = s_q.w;
			REG_STATUS:
				rd_data[ST_W-1:0] = s_q.st;
			REG_BANK:
				rd_data[3:0] = s_q.bank_select_reg;
			REG_PTR0:
				rd_data[11:0] = s_q.ptr[0];
			REG_PTR1:
				rd_data[11:0] = s_q.ptr[1];
			REG_PTR2:
				rd_data[11:0] = s_q.ptr[2];
			REG_MADDR:
				rd_data[11:0] = s_q.maddr;
			REG_MDATA:
				rd_data[7:0] = mrd;
			default:
				rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			s_q.phase <= PH_FETCH;
			s_q.psel <= 2'h0;
			s_q.w <= ACCUM_RST;
			s_q.st <= STATUS_RST;
			s_q.bank_select_reg <= BANK_RST;
			s_q.ptr <= {PTR_NUM{PTR_RST}};
			s_q.ext <= EXT_RST;
			s_q.maddr <= PTR_RST;
		end
		else
			s_q <= s_d;
	end

	assign accum_out = s_q.w;
	assign neg_flag_out = s_q.st[ST_N];
	assign zero_flag_out = s_q.st[ST_Z];
	// One-hot code: bit 1 is the second-word phase, so the output is the flop itself
	assign ptr_pending_out = s_q.phase[1];

	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	orlit_res_a: assert property (
		is_orlit |=> s_q.w == ($past(s_q.w) | $past(instr_in[7:0])))
		else $error("literal OR result wrong");

	flags_keep_a: assert property (
		byte_op |=> {s_q.st[ST_OV], s_q.st[ST_DC], s_q.st[ST_C]}
			== $past({s_q.st[ST_OV], s_q.st[ST_DC], s_q.st[ST_C]}))
		else $error("byte operation touched other flags");

	orreg_w_a: assert property (
		is_orreg && !dest_f |=> s_q.w == ($past(s_q.w) | $past(frd)))
		else $error("register OR to accumulator wrong");

	dest_file_a: assert property (
		(is_orreg || is_move) && dest_f |-> mem_we && mem_wa == faddr && mem_wd == res ##1 $stable(s_q.w))
		else $error("file destination not written back");

	bank_sel_a: assert property (
		go && bank_a |-> faddr[11:8] == s_q.bank_select_reg && faddr[7:0] == fld)
		else $error("banked address wrong");

	ilo_addr_a: assert property (
		go && !bank_a && s_q.ext && fld <= ILO_MAX |-> faddr == 12'(s_q.ptr[PTR_IDX_ILO] + {4'h0, fld}))
		else $error("indexed literal offset address wrong");

	ptr_hi_a: assert property (
		is_p1 && instr_in[5:4] == PTR_SEL_MAX |=> s_q.phase == PH_PTRLO
			&& s_q.ptr[2][11:8] == $past(instr_in[3:0]))
		else $error("pointer high nibble not loaded");

	ptr_lo_a: assert property (
		s_q.phase == PH_PTRLO && instr_valid_in && instr_in[15:8] == OP_PLOAD2 && s_q.psel == PTR_SEL_MAX
			|=> s_q.ptr[2] == {$past(s_q.ptr[2][11:8]), $past(instr_in[7:0])})
		else $error("pointer low byte not loaded");

	ptr_flags_a: assert property (
		is_p1 && p1_legal ##1 instr_valid_in |=> $stable(s_q.st) && s_q.phase == PH_FETCH
			&& $past(s_q.st, 2) == s_q.st)
		else $error("pointer load changed flags or took extra cycles");

	move_w_a: assert property (
		is_move && !dest_f |=> s_q.w == $past(frd))
		else $error("move to accumulator wrong");

	flag_calc_a: assert property (
		byte_op |=> s_q.st[ST_Z] == ($past(res) == 8'h00) && s_q.st[ST_N] == $past(res[7]))
		else $error("negative or zero flag wrong");

	ptr_load_c: cover property (is_p1 && p1_legal ##1 (!instr_valid_in)[*2] ##1 instr_valid_in);
	ilo_mode_c: cover property (byte_op && !bank_a && s_q.ext && fld <= ILO_MAX);
	file_dest_c: cover property (is_orreg && dest_f ##1 is_move && !dest_f);
	sw_mem_c: cover property (sw_we && sw_addr == REG_MDATA);
endmodule : ompld_core
`default_nettype wire

// *** rtl/ompld_pkg.sv ***
`default_nettype none
package ompld_pkg;
	// Instruction encodings
	localparam logic [7:0] OP_ORLIT = 8'h09;
	localparam logic [5:0] OP_ORREG = 6'h04;
	localparam logic [5:0] OP_MOVE = 6'h14;
	localparam logic [9:0] OP_PLOAD1 = 10'h3B8;
	localparam logic [7:0] OP_PLOAD2 = 8'hF0;
	localparam logic [1:0] PTR_SEL_MAX = 2'h2;
	localparam int PTR_NUM = 3;
	localparam int PTR_IDX_ILO = 2;
	// Bank addressing
	localparam logic [7:0] ILO_MAX = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;
	localparam int MEM_DEPTH = 4096;
	// Status bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	localparam int ST_W = 5;
	// Register map, byte addresses
	localparam int AW = 8;
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_ACCUM = 8'h04;
	localparam logic [AW-1:0] REG_STATUS = 8'h08;
	localparam logic [AW-1:0] REG_BANK = 8'h0C;
	localparam logic [AW-1:0] REG_PTR0 = 8'h10;
	localparam logic [AW-1:0] REG_PTR1 = 8'h14;
	localparam logic [AW-1:0] REG_PTR2 = 8'h18;
	localparam logic [AW-1:0] REG_MADDR = 8'h1C;
	localparam logic [AW-1:0] REG_MDATA = 8'h20;
	localparam int CTRL_EXT = 0;
	// Values after reset
	localparam logic [7:0] ACCUM_RST = 8'h00;
	localparam logic [ST_W-1:0] STATUS_RST = 5'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic EXT_RST = 1'b0;
	// Bus answers
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {PH_FETCH = 2'b01, PH_PTRLO = 2'b10} ompld_phase_t;
endpackage : ompld_pkg
`default_nettype wire

// *** rtl/ompld_dmem.sv ***
`default_nettype none
module ompld_dmem (
	// Clock
	input wire logic clk_in,
	// Write port
	input wire logic we_in,
	input wire logic [11:0] waddr_in,
	input wire logic [7:0] wdata_in,
	// Read ports, combinational
	input wire logic [11:0] raddr_a_in,
	output logic [7:0] rdata_a_out,
	input wire logic [11:0] raddr_b_in,
	output logic [7:0] rdata_b_out
);
	import ompld_pkg::*;
	logic [7:0] mem [0:MEM_DEPTH-1];

	// Asynchronous reads keep a whole instruction inside one clock
	always_ff @(posedge clk_in)
	begin
		if (we_in)
			mem[waddr_in] <= wdata_in;
	end

	assign rdata_a_out = mem[raddr_a_in];
	assign rdata_b_out = mem[raddr_b_in];
endmodule : ompld_dmem
`default_nettype wire

// *** rtl/ompld_axil.sv ***
`default_nettype none
module ompld_axil (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// AXI4-Lite slave
	input wire logic [ompld_pkg::AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ompld_pkg::AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Register side
	input wire logic core_idle_in,
	output logic wr_en_out,
	output logic [ompld_pkg::AW-1:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	input wire logic wr_err_in,
	output logic [ompld_pkg::AW-1:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_err_in
);
	import ompld_pkg::*;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic have_aw;
		logic have_w;
		logic have_ar;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [AW-1:0] araddr;
	} ompld_bus_t;
	ompld_bus_t s_q, s_d;

	// Writes wait while an instruction word is present, so core and software never collide
	always_comb
	begin
		s_d = s_q;
		wr_en_out = s_q.have_aw && s_q.have_w && core_idle_in;
		if (s_axi_awvalid_in && s_q.awready)
		begin
			s_d.have_aw = 1'b1;
			s_d.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_q.wready)
		begin
			s_d.have_w = 1'b1;
			s_d.wdata = s_axi_wdata_in;
		end
		if (wr_en_out)
		begin
			s_d.have_aw = 1'b0;
			s_d.have_w = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_err_in ? RESP_SLVERR : RESP_OK;
		end
		if (s_q.bvalid && s_axi_bready_in)
			s_d.bvalid = 1'b0;
		if (s_axi_arvalid_in && s_q.arready)
		begin
			s_d.have_ar = 1'b1;
			s_d.araddr = s_axi_araddr_in;
		end
		if (s_q.have_ar)
		begin
			s_d.have_ar = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_data_in;
			s_d.rresp = rd_err_in ? RESP_SLVERR : RESP_OK;
		end
		if (s_q.rvalid && s_axi_rready_in)
			s_d.rvalid = 1'b0;
		s_d.awready = !s_d.have_aw && !s_d.bvalid;
		s_d.wready = !s_d.have_w && !s_d.bvalid;
		s_d.arready = !s_d.have_ar && !s_d.rvalid;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign s_axi_awready_out = s_q.awready;
	assign s_axi_wready_out = s_q.wready;
	assign s_axi_bvalid_out = s_q.bvalid;
	assign s_axi_bresp_out = s_q.bresp;
	assign s_axi_arready_out = s_q.arready;
	assign s_axi_rvalid_out = s_q.rvalid;
	assign s_axi_rresp_out = s_q.rresp;
	assign s_axi_rdata_out = s_q.rdata;
	assign wr_addr_out = s_q.awaddr;
	assign wr_data_out = s_q.wdata;
	assign rd_addr_out = s_q.araddr;
endmodule : ompld_axil
`default_nettype wire

// *** verification/ompld_fetch.sv ***
`default_nettype none
module ompld_fetch (
	// Clock
	input wire logic clk_in,
	// Instruction words toward the core
	output logic instr_valid_out,
	output logic [15:0] instr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// An idle bus shows the inverse of the last word, so a stale word is never mistaken for a new one
	initial
	begin
		instr_valid_out = 1'b0;
		instr_out = 16'hFFFF;
	end
	// Words go out back to back, one per rising edge
	task automatic run(input logic [15:0] w[$]);
		foreach (w[i])
		begin
			@(posedge clk_in);
			instr_valid_out <= 1'b1;
			instr_out <= w[i];
		end
		@(posedge clk_in);
		instr_valid_out <= 1'b0;
		instr_out <= ~w[w.size()-1];
		#1;
	endtask : run
endmodule : ompld_fetch
`default_nettype wire

// *** verification/ompld_core_tb.sv ***
`default_nettype none
module ompld_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ompld_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in;
	logic [7:0] awaddr;
	logic [7:0] araddr;
	logic [31:0] wdata;
	logic awvalid;
	logic wvalid;
	logic bready;
	logic arvalid;
	logic rready;
	logic awready;
	logic wready;
	logic bvalid;
	logic arready;
	logic rvalid;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic [7:0] accum;
	logic neg;
	logic zero;
	logic pend;
	logic instr_valid;
	logic [15:0] instr;
	int n_fail = 0;
	int checks_done = 0;

	always #5 clk_in = ~clk_in;

	ompld_fetch FETCH (.clk_in(clk_in), .instr_valid_out(instr_valid), .instr_out(instr));

	ompld_core DUT (
		.clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid), .instr_in(instr),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.accum_out(accum), .neg_flag_out(neg), .zero_flag_out(zero), .ptr_pending_out(pend)
	);

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// A master that waits for every answer, with a bound that ends the run on a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ok;
		logic [1:0] r;
		ok = 1'b0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++)
		begin
			@(posedge clk_in);
			if (bvalid === 1'b1)
			begin
				ok = 1'b1;
				r = bresp;
			end
			awvalid <= awvalid && awready !== 1'b1;
			wvalid <= wvalid && wready !== 1'b1;
			bready <= !ok;
		end
		if (!ok)
		begin
			n_fail++;
			report_and_stop();
		end
		#1;
		chk(r, er, "bresp");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
		bit ok;
		logic [1:0] r;
		logic [31:0] d;
		ok = 1'b0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++)
		begin
			@(posedge clk_in);
			if (rvalid === 1'b1)
			begin
				ok = 1'b1;
				r = rresp;
				d = rdata;
			end
			arvalid <= arvalid && arready !== 1'b1;
			rready <= !ok;
		end
		if (!ok)
		begin
			n_fail++;
			report_and_stop();
		end
		#1;
		chk(d, exp, what);
		chk(r, er, "rresp");
	endtask : rd

	task automatic t_reset();
		chk({accum, neg, zero, pend}, {ACCUM_RST, 3'b000}, "core reset");
		rd(REG_PTR0, PTR_RST, RESP_OK, "ptr0 reset");
		rd(REG_STATUS, STATUS_RST, RESP_OK, "status reset");
		rd(8'h24, 32'h0, RESP_SLVERR, "unmapped read");
		wr(8'h24, 32'h1, RESP_SLVERR);
	endtask : t_reset

	task automatic t_or_literal();
		wr(REG_STATUS, 32'h0F, RESP_OK);
		wr(REG_ACCUM, 32'h9A, RESP_OK);
		FETCH.run('{16'h0935});
		chk({accum, neg, zero}, {8'hBF, 2'b10}, "or literal");
		rd(REG_STATUS, 32'h1B, RESP_OK, "other flags kept");
		wr(REG_ACCUM, 32'h00, RESP_OK);
		FETCH.run('{16'h0900});
		chk({accum, neg, zero}, {8'h00, 2'b01}, "zero result");
	endtask : t_or_literal

	task automatic t_file_ops();
		wr(REG_BANK, 32'h3, RESP_OK);
		wr(REG_MADDR, 32'hFFF, RESP_OK);
		wr(REG_MDATA, 32'h00, RESP_OK);
		wr(REG_MADDR, 32'h070, RESP_OK);
		wr(REG_MDATA, 32'h80, RESP_OK);
		wr(REG_ACCUM, 32'h91, RESP_OK);
		wr(REG_MADDR, 32'h345, RESP_OK);
		// Last bus write leaves the window address behind while the core writes back
		wr(REG_MDATA, 32'h13, RESP_OK);
		FETCH.run('{16'h1345});
		chk(accum, 8'h91, "or into file keeps accum");
		rd(REG_MDATA, 32'h93, RESP_OK, "or into file");
		FETCH.run('{16'h1145});
		chk({accum, neg, zero}, {8'h93, 2'b10}, "or into accum");
		FETCH.run('{16'h50FF});
		chk({accum, neg, zero}, {8'h00, 2'b01}, "move top of access bank");
		FETCH.run('{16'h5070});
		chk({accum, neg, zero}, {8'h80, 2'b10}, "move low access bank");
	endtask : t_file_ops

	task automatic t_pointer();
		FETCH.run('{16'hEE23});
		chk(pend, 1'b1, "waits for second word");
		rd(REG_PTR2, 32'h300, RESP_OK, "high nibble first");
		FETCH.run('{16'hF0AB});
		chk(pend, 1'b0, "second word ends load");
		rd(REG_PTR2, 32'h3AB, RESP_OK, "ptr2 loaded");
		rd(REG_STATUS, 32'h1B, RESP_OK, "flags kept");
		FETCH.run('{16'hEE01, 16'hF022, 16'hEE1F, 16'hF0FF, 16'hEE30});
		rd(REG_PTR0, 32'h122, RESP_OK, "ptr0 loaded");
		rd(REG_PTR1, 32'hFFF, RESP_OK, "ptr1 loaded");
		chk(pend, 1'b0, "selector 3 ignored");
	endtask : t_pointer

	// Pointer 2 holds 3ABh from the previous scenario
	task automatic t_indexed();
		wr(REG_CTRL, 32'h1, RESP_OK);
		wr(REG_MADDR, 32'h40A, RESP_OK);
		wr(REG_MDATA, 32'h5A, RESP_OK);
		wr(REG_MADDR, 32'h060, RESP_OK);
		wr(REG_MDATA, 32'h01, RESP_OK);
		FETCH.run('{16'h505F});
		chk(accum, 8'h5A, "indexed at 5Fh");
		FETCH.run('{16'h5060});
		chk(accum, 8'h01, "direct above 5Fh");
	endtask : t_indexed

	// A reset in mid-load must drop the pending second word
	task automatic t_mid_reset();
		FETCH.run('{16'hEE20});
		chk(pend, 1'b1, "pending before reset");
		@(posedge clk_in);
		srst_in <= 1'b1;
		@(posedge clk_in);
		srst_in <= 1'b0;
		#1;
		chk({accum, neg, zero, pend}, {ACCUM_RST, 3'b000}, "mid-run reset");
		FETCH.run('{16'hF055});
		rd(REG_PTR2, PTR_RST, RESP_OK, "no stale second word");
	endtask : t_mid_reset

	initial
	begin
		srst_in = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		t_reset();
		t_or_literal();
		t_file_ops();
		t_pointer();
		t_indexed();
		t_mid_reset();
		report_and_stop();
	end
endmodule : ompld_core_tb
`default_nettype wire
